/* verilog/dftm_pkg.sv */
package dftm_pkg;

  // Timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
  localparam int unsigned PHASE_LOSS_S  = 1;
  localparam int unsigned PHASE_LOSS_MS = PHASE_LOSS_S * MS_PER_S;
  localparam int unsigned RETRY_WAIT_MS = 1000;
  localparam int unsigned LS_OL_MS      = 500;
  localparam int unsigned GATE_CONF_CYC = 8;
  // 0.2 Hz in 0.01 Hz units
  localparam logic [15:0] LS_FREQ_CHZ   = 16'h0014;

  // Register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_BRAKE = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;

  // Control fields
  localparam int unsigned CB_PHASE = 0;
  localparam int unsigned CB_BRAKE = 1;
  localparam int unsigned CB_COMM  = 2;
  localparam int unsigned CB_ROT   = 4;
  localparam int unsigned CB_RETRY = 6;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] BRAKE_RST = 32'h0000_0064;

  // Interrupt bits
  localparam int unsigned INT_W    = 4;
  localparam int unsigned IB_TRIP  = 0;
  localparam int unsigned IB_COMM  = 1;
  localparam int unsigned IB_LIMIT = 2;
  localparam int unsigned IB_CLEAR = 3;

  localparam logic [1:0] COMM_TRIP = 2'h0;
  localparam logic [1:0] ROT_FWD   = 2'h1;
  localparam logic [1:0] ROT_REV   = 2'h2;

  // Reset classes
  localparam logic [1:0] CLS_ANY   = 2'h0;
  localparam logic [1:0] CLS_TERM  = 2'h1;
  localparam logic [1:0] CLS_POWER = 2'h2;

  // Error codes
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam logic [7:0] ERR_MAIN   = 8'h25;
  localparam logic [7:0] ERR_SW     = 8'h30;
  localparam logic [7:0] ERR_ESTOP  = 8'h37;
  localparam logic [7:0] ERR_PHASE  = 8'h34;
  localparam logic [7:0] ERR_THERM  = 8'h35;
  localparam logic [7:0] ERR_BRAKE  = 8'h36;
  localparam logic [7:0] ERR_LS     = 8'h38;
  localparam logic [7:0] ERR_MODBUS = 8'h41;
  localparam logic [7:0] ERR_OPT1   = 8'h60;
  localparam logic [7:0] ERR_OPT2   = 8'h70;

  // Synchronised pin indices
  localparam int unsigned P_PHASE = 0;
  localparam int unsigned P_SWF   = 1;
  localparam int unsigned P_THERM = 2;
  localparam int unsigned P_BKCF  = 3;
  localparam int unsigned P_ESTOP = 4;
  localparam int unsigned P_ESTEN = 5;
  localparam int unsigned P_OL    = 6;
  localparam int unsigned P_MB    = 7;
  localparam int unsigned P_OPT1  = 8;
  localparam int unsigned P_OPT2  = 9;
  localparam int unsigned P_UV    = 10;
  localparam int unsigned P_PNL   = 11;
  localparam int unsigned P_FWD   = 12;
  localparam int unsigned P_REV   = 13;
  localparam int unsigned P_RSTT  = 14;
  localparam int unsigned P_KEY   = 15;
  localparam int unsigned P_PWR   = 16;
  localparam int unsigned P_GFB   = 17;
  localparam int unsigned NPIN    = 18;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_TRIP  = 3'b010,
    ST_RETRY = 3'b100
  } dftm_state_e;

endpackage

/* verilog/dftm_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01: Phase lost one second trips when selected
// R02: Unconfirmed switch feedback raises main-circuit trip
// R03: Power-cycle class ignores terminal and key
// R04: Terminal class ignores operator panel reset
// R05: Switch-stage fault trips without automatic retry
// R06: Thermistor overheating trips and shuts off
// R07: Brake confirmation timeout trips when selected
// R08: Enabled emergency stop blocks output, latches
// R09: Low-speed overload accumulator trips output
// R10: Modbus timeout follows communication error action
// R11: Option ports report separate code groups
// R12: Undervoltage shows waiting state
// R13: Operator panel link failure indicated
// R14: Retry wait shows restart standby
// R15: Forbidden direction refused and flagged
// R16: Supply removal shows power-shutoff indication
// R17: Trip held until accepted reset clears; retryable trips with retry enabled clear after the retry wait
module dftm_top #(
  parameter int unsigned MS_CYCLES = dftm_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Protection pins, asynchronous
  input  wire logic        phase_missing,
  input  wire logic        sw_stage_fault,
  input  wire logic        motor_thermistor_input,
  input  wire logic        brake_confirm,
  input  wire logic        emergency_stop_input,
  input  wire logic        emergency_stop_enable_switch,
  input  wire logic        overload_detect,
  input  wire logic        modbus_timeout,
  input  wire logic        opt1_error,
  input  wire logic        opt2_error,
  input  wire logic        undervoltage,
  input  wire logic        panel_link_error,
  input  wire logic        run_fwd_cmd,
  input  wire logic        run_rev_cmd,
  input  wire logic        trip_reset_terminal,
  input  wire logic        panel_reset_key,
  input  wire logic        power_lost,
  input  wire logic        gate_feedback,
  // Same-clock inputs
  input  wire logic        gate_cmd,
  input  wire logic [15:0] out_freq_chz,
  input  wire logic [3:0]  opt1_subcode,
  input  wire logic [3:0]  opt2_subcode,
  // Drive outputs
  output logic             output_shutoff,
  output logic             brake_release,
  output logic             run_fwd_ok,
  output logic             run_rev_ok,
  // Indications
  output logic [7:0]       err_code,
  output logic             restart_standby,
  output logic             uv_standby,
  output logic             panel_comm_err,
  output logic             run_limited,
  output logic             power_shutoff_ind,
  // Interrupt
  output logic             irq
);

  localparam int unsigned NP = dftm_pkg::NPIN;

  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_r;
  logic [NP-1:0] s_q;
  logic [17:0]   tick_cnt_r;
  logic          tick;
  logic [31:0]   ctrl_r;
  logic [31:0]   brake_wait_r;
  logic [dftm_pkg::INT_W-1:0] istat_r;
  logic [dftm_pkg::INT_W-1:0] imask_r;
  logic [dftm_pkg::INT_W-1:0] ev;
  logic [31:0]   prdata_r;
  logic [31:0]   rd_val;
  logic          mapped;
  logic          acc_wr;
  logic          acc_rd;
  dftm_pkg::dftm_state_e st_r;
  logic [7:0]    err_code_r;
  logic [1:0]    cls_r;
  logic          rty_r;
  logic          t_req;
  logic [7:0]    t_code;
  logic [1:0]    t_cls;
  logic          t_retry;
  logic [10:0]   pl_cnt_r;
  logic [15:0]   bk_cnt_r;
  logic [9:0]    ls_acc_r;
  logic [9:0]    rt_cnt_r;
  logic [3:0]    gm_cnt_r;
  logic          gm_trip;
  logic          pl_trip;
  logic          bk_to;
  logic          ls_trip;
  logic          estop_act;
  logic          rstt_d_r;
  logic          key_d_r;
  logic          mb_d_r;
  logic          lim_d_r;
  logic          rst_ok;
  logic          rty_go;
  logic          lim_now;
  logic          shut_r;
  logic          brake_rel_r;
  logic          fwd_ok_r;
  logic          rev_ok_r;
  logic          rty_ind_r;
  logic          uv_r;
  logic          pnl_r;
  logic          lim_r;
  logic          pwr_r;
  logic          irq_r;
  logic [1:0]    rot;
  logic [1:0]    comm_act;

  assign pin_raw = {gate_feedback, power_lost, panel_reset_key, trip_reset_terminal,
                    run_rev_cmd, run_fwd_cmd, panel_link_error, undervoltage,
                    opt2_error, opt1_error, modbus_timeout, overload_detect,
                    emergency_stop_enable_switch, emergency_stop_input, brake_confirm,
                    motor_thermistor_input, sw_stage_fault, phase_missing};

  // Two-stage synchronisers, first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          s1_r[gi] <= 1'b0;
          s_q[gi]  <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= pin_raw[gi];
          s_q[gi]  <= s1_r[gi];
        end
      end
    end
  endgenerate

  assign rot      = ctrl_r[dftm_pkg::CB_ROT +: 2];
  assign comm_act = ctrl_r[dftm_pkg::CB_COMM +: 2];

  // Millisecond tick shared by all slow timers
  assign tick = (tick_cnt_r == 18'(MS_CYCLES - 1));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || tick)
      tick_cnt_r <= 18'h0;
    else
      tick_cnt_r <= tick_cnt_r + 18'h1;
  end

  // Phase loss duration
  assign pl_trip = (pl_cnt_r == 11'(dftm_pkg::PHASE_LOSS_MS));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !(s_q[dftm_pkg::P_PHASE] && ctrl_r[dftm_pkg::CB_PHASE]))
      pl_cnt_r <= 11'h0;
    else if (tick && !pl_trip)
      pl_cnt_r <= pl_cnt_r + 11'h1; // R01
  end

  // Feedback lags the command by the synchroniser; mismatch must persist
  assign gm_trip = (gm_cnt_r == 4'(dftm_pkg::GATE_CONF_CYC));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || (gate_cmd == s_q[dftm_pkg::P_GFB]))
      gm_cnt_r <= 4'h0;
    else if (!gm_trip)
      gm_cnt_r <= gm_cnt_r + 4'h1; // R02
  end

  // Brake confirmation wait, counted from brake release
  assign bk_to = (bk_cnt_r >= brake_wait_r[15:0]);
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !brake_rel_r || s_q[dftm_pkg::P_BKCF])
      bk_cnt_r <= 16'h0;
    else if (tick && !bk_to)
      bk_cnt_r <= bk_cnt_r + 16'h1; // R07
  end

  // Low-speed thermal accumulator, decays when relieved
  assign ls_trip = (ls_acc_r == 10'(dftm_pkg::LS_OL_MS));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ls_acc_r <= 10'h0;
    else if (tick && s_q[dftm_pkg::P_OL] && out_freq_chz <= dftm_pkg::LS_FREQ_CHZ)
    begin
      if (!ls_trip)
        ls_acc_r <= ls_acc_r + 10'h1; // R09
    end
    else if (tick && ls_acc_r != 10'h0)
      ls_acc_r <= ls_acc_r - 10'h1;
  end

  assign estop_act = s_q[dftm_pkg::P_ESTOP] && s_q[dftm_pkg::P_ESTEN];

  // Trip cause, highest priority first
  always_comb
  begin
    t_req   = 1'b1;
    t_code  = dftm_pkg::ERR_NONE;
    t_cls   = dftm_pkg::CLS_ANY;
    t_retry = 1'b1;
    if (gm_trip)
    begin
      t_code  = dftm_pkg::ERR_MAIN; // R02
      t_cls   = dftm_pkg::CLS_POWER; // R03
      t_retry = 1'b0;
    end
    else if (s_q[dftm_pkg::P_SWF])
    begin
      t_code  = dftm_pkg::ERR_SW;
      t_retry = 1'b0; // R05
    end
    else if (estop_act)
    begin
      t_code  = dftm_pkg::ERR_ESTOP; // R08
      t_cls   = dftm_pkg::CLS_TERM; // R04
      t_retry = 1'b0;
    end
    else if (pl_trip)
      t_code = dftm_pkg::ERR_PHASE; // R01
    else if (s_q[dftm_pkg::P_THERM])
      t_code = dftm_pkg::ERR_THERM; // R06
    else if (bk_to && brake_rel_r && !s_q[dftm_pkg::P_BKCF])
      t_code = dftm_pkg::ERR_BRAKE; // R07
    else if (ls_trip)
      t_code = dftm_pkg::ERR_LS; // R09
    else if (s_q[dftm_pkg::P_MB] && comm_act == dftm_pkg::COMM_TRIP)
      t_code = dftm_pkg::ERR_MODBUS; // R10
    else if (s_q[dftm_pkg::P_OPT1])
      t_code = dftm_pkg::ERR_OPT1 | {4'h0, opt1_subcode}; // R11
    else if (s_q[dftm_pkg::P_OPT2])
      t_code = dftm_pkg::ERR_OPT2 | {4'h0, opt2_subcode}; // R11
    else
      t_req = 1'b0;
  end

  // Reset sources accepted per class
  assign rst_ok = (s_q[dftm_pkg::P_RSTT] && !rstt_d_r && cls_r != dftm_pkg::CLS_POWER) ||
                  (s_q[dftm_pkg::P_KEY] && !key_d_r && cls_r == dftm_pkg::CLS_ANY); // R03 R04
  assign rty_go = ctrl_r[dftm_pkg::CB_RETRY] && rty_r;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r       <= dftm_pkg::ST_RUN;
      err_code_r <= dftm_pkg::ERR_NONE;
      cls_r      <= dftm_pkg::CLS_ANY;
      rty_r      <= 1'b0;
    end
    else
    begin
      case (st_r)
        dftm_pkg::ST_RUN:
          if (t_req)
          begin
            st_r       <= dftm_pkg::ST_TRIP;
            err_code_r <= t_code;
            cls_r      <= t_cls;
            rty_r      <= t_retry;
          end
        dftm_pkg::ST_TRIP:
          if (rst_ok)
          begin
            st_r       <= dftm_pkg::ST_RUN;
            err_code_r <= dftm_pkg::ERR_NONE;
          end
          else if (rty_go)
            st_r <= dftm_pkg::ST_RETRY; // R14
        dftm_pkg::ST_RETRY:
          if (rst_ok || rt_cnt_r == 10'(dftm_pkg::RETRY_WAIT_MS))
          begin
            st_r       <= dftm_pkg::ST_RUN;
            err_code_r <= dftm_pkg::ERR_NONE;
          end
        default:
          st_r <= dftm_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || st_r != dftm_pkg::ST_RETRY)
      rt_cnt_r <= 10'h0;
    else if (tick)
      rt_cnt_r <= rt_cnt_r + 10'h1;
  end

  assign lim_now = (s_q[dftm_pkg::P_FWD] && rot == dftm_pkg::ROT_REV) ||
                   (s_q[dftm_pkg::P_REV] && rot == dftm_pkg::ROT_FWD); // R15

  // Registered drive and indication outputs
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      shut_r      <= 1'b1;
      brake_rel_r <= 1'b0;
      fwd_ok_r    <= 1'b0;
      rev_ok_r    <= 1'b0;
      rty_ind_r   <= 1'b0;
      uv_r        <= 1'b0;
      pnl_r       <= 1'b0;
      lim_r       <= 1'b0;
      pwr_r       <= 1'b0;
      rstt_d_r    <= 1'b0;
      key_d_r     <= 1'b0;
      mb_d_r      <= 1'b0;
      lim_d_r     <= 1'b0;
    end
    else
    begin
      // Held off while tripped, in standby or on a supply fault
      shut_r      <= (st_r != dftm_pkg::ST_RUN) || t_req || estop_act ||
                     s_q[dftm_pkg::P_UV] || s_q[dftm_pkg::P_PWR]; // R08 R17
      fwd_ok_r    <= s_q[dftm_pkg::P_FWD] && rot != dftm_pkg::ROT_REV && !shut_r; // R15
      rev_ok_r    <= s_q[dftm_pkg::P_REV] && rot != dftm_pkg::ROT_FWD && !shut_r; // R15
      brake_rel_r <= ctrl_r[dftm_pkg::CB_BRAKE] && (fwd_ok_r || rev_ok_r) && !shut_r;
      rty_ind_r   <= (st_r == dftm_pkg::ST_RETRY); // R14
      uv_r        <= s_q[dftm_pkg::P_UV]; // R12
      pnl_r       <= s_q[dftm_pkg::P_PNL]; // R13
      lim_r       <= lim_now;
      pwr_r       <= s_q[dftm_pkg::P_PWR]; // R16
      rstt_d_r    <= s_q[dftm_pkg::P_RSTT];
      key_d_r     <= s_q[dftm_pkg::P_KEY];
      mb_d_r      <= s_q[dftm_pkg::P_MB];
      lim_d_r     <= lim_now;
    end
  end

  // Interrupt events
  assign ev[dftm_pkg::IB_TRIP]  = (st_r == dftm_pkg::ST_RUN) && t_req;
  assign ev[dftm_pkg::IB_COMM]  = s_q[dftm_pkg::P_MB] && !mb_d_r && comm_act != dftm_pkg::COMM_TRIP;
  assign ev[dftm_pkg::IB_LIMIT] = lim_now && !lim_d_r;
  assign ev[dftm_pkg::IB_CLEAR] = (st_r != dftm_pkg::ST_RUN) && rst_ok;

  // APB slave, zero wait states; read data captured in setup
  assign mapped = (paddr == dftm_pkg::OFS_CTRL) || (paddr == dftm_pkg::OFS_BRAKE) ||
                  (paddr == dftm_pkg::OFS_STAT) || (paddr == dftm_pkg::OFS_ISTAT) ||
                  (paddr == dftm_pkg::OFS_IMASK);
  assign acc_wr = psel && penable && pwrite && mapped;
  assign acc_rd = psel && penable && !pwrite;

  always_comb
  begin
    rd_val = 32'h0;
    case (paddr)
      dftm_pkg::OFS_CTRL:  rd_val = ctrl_r;
      dftm_pkg::OFS_BRAKE: rd_val = brake_wait_r;
      dftm_pkg::OFS_STAT:  rd_val = {18'h0, pwr_r, lim_r, pnl_r, uv_r, rty_ind_r,
                                     st_r != dftm_pkg::ST_RUN, err_code_r};
      dftm_pkg::OFS_ISTAT: rd_val = {28'h0, istat_r};
      dftm_pkg::OFS_IMASK: rd_val = {28'h0, imask_r};
      default:             rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl_r       <= dftm_pkg::CTRL_RST;
      brake_wait_r <= dftm_pkg::BRAKE_RST;
      imask_r      <= 4'h0;
      prdata_r     <= 32'h0;
    end
    else
    begin
      if (psel && !penable && !pwrite)
        prdata_r <= rd_val;
      if (acc_wr && paddr == dftm_pkg::OFS_CTRL)
        ctrl_r <= {25'h0, pwdata[6:0]};
      if (acc_wr && paddr == dftm_pkg::OFS_BRAKE)
        brake_wait_r <= {16'h0, pwdata[15:0]};
      if (acc_wr && paddr == dftm_pkg::OFS_IMASK)
        imask_r <= pwdata[3:0];
    end
  end

  // Read clears only what setup captured, so no event between is lost
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      istat_r <= 4'h0;
    else if (acc_rd && paddr == dftm_pkg::OFS_ISTAT)
      istat_r <= (istat_r & ~prdata_r[dftm_pkg::INT_W-1:0]) | ev;
    else
      istat_r <= istat_r | ev;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(istat_r & imask_r);
  end

  assign pready            = 1'b1;
  assign pslverr           = psel && penable && !mapped;
  assign prdata            = prdata_r;
  assign output_shutoff    = shut_r;
  assign brake_release     = brake_rel_r;
  assign run_fwd_ok        = fwd_ok_r;
  assign run_rev_ok        = rev_ok_r;
  assign err_code          = err_code_r;
  assign restart_standby   = rty_ind_r;
  assign uv_standby        = uv_r;
  assign panel_comm_err    = pnl_r;
  assign run_limited       = lim_r;
  assign power_shutoff_ind = pwr_r;
  assign irq               = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_estop;
    estop_act && st_r == dftm_pkg::ST_RUN && !gm_trip && !s_q[dftm_pkg::P_SWF];
  endsequence
  sequence s_estop_held;
    st_r == dftm_pkg::ST_TRIP && err_code_r == dftm_pkg::ERR_ESTOP && output_shutoff;
  endsequence

  AST_PHASE_TRIP: assert property (st_r == dftm_pkg::ST_RUN && pl_trip |=> st_r == dftm_pkg::ST_TRIP) // R01
    else $error("phase loss did not trip");
  AST_POWER_ONLY: assert property (st_r == dftm_pkg::ST_TRIP && cls_r == dftm_pkg::CLS_POWER
    |=> st_r == dftm_pkg::ST_TRIP ##1 st_r == dftm_pkg::ST_TRIP) // R03
    else $error("power-cycle trip was cleared");
  AST_TERM_ONLY: assert property (st_r == dftm_pkg::ST_TRIP && cls_r == dftm_pkg::CLS_TERM
    && !(s_q[dftm_pkg::P_RSTT] && !rstt_d_r) |=> st_r == dftm_pkg::ST_TRIP) // R04
    else $error("terminal-class trip cleared by panel");
  AST_SW_NO_RETRY: assert property (err_code_r == dftm_pkg::ERR_SW && st_r == dftm_pkg::ST_TRIP
    |=> st_r != dftm_pkg::ST_RETRY) // R05
    else $error("switch fault entered retry");
  AST_THERM: assert property (st_r == dftm_pkg::ST_RUN && s_q[dftm_pkg::P_THERM]
    |=> st_r == dftm_pkg::ST_TRIP && output_shutoff) // R06
    else $error("thermistor did not trip");
  AST_BRAKE: assert property (st_r == dftm_pkg::ST_RUN && brake_rel_r && !s_q[dftm_pkg::P_BKCF]
    && bk_to |=> st_r == dftm_pkg::ST_TRIP) // R07
    else $error("brake timeout did not trip");
  AST_ESTOP: assert property (s_estop |=> s_estop_held) // R08
    else $error("emergency stop not latched");
  AST_LS_TRIP: assert property (st_r == dftm_pkg::ST_RUN && ls_trip |=> st_r == dftm_pkg::ST_TRIP) // R09
    else $error("low-speed overload did not trip");
  AST_LIMIT: assert property (rot == dftm_pkg::ROT_FWD && s_q[dftm_pkg::P_REV]
    |=> run_limited && !run_rev_ok) // R15
    else $error("forbidden direction not refused");
  AST_HOLD: assert property (st_r == dftm_pkg::ST_TRIP && !rst_ok && !rty_go
    |=> st_r == dftm_pkg::ST_TRIP && $stable(err_code_r) && output_shutoff) // R17
    else $error("trip released without reset");
  AST_RETRY_IND: assert property (st_r == dftm_pkg::ST_RETRY |=> restart_standby) // R14
    else $error("restart standby not shown");

endmodule

/* dv/dftm_plant.sv */
`timescale 1ns/1ps
module dftm_plant (
  // Clock
  input  wire logic core_clk,
  // Drive side
  input  wire logic gate_cmd,
  input  wire logic brake_release,
  // Fault injection
  input  wire logic bad_gate,
  input  wire logic brake_stuck,
  // Feedback
  output logic      gate_feedback,
  output logic      brake_confirm
);
  // Feedback lags the command by a cycle, as a real stage would
  always_ff @(posedge core_clk)
  begin
    gate_feedback <= gate_cmd ^ bad_gate;
    brake_confirm <= brake_release & ~brake_stuck;
  end
endmodule

/* dv/tb_drive_fault_trip_manager.sv */
`timescale 1ns/1ps
module tb_drive_fault_trip_manager;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr, err;
  logic [31:0] pwdata, prdata, rd;
  logic        ph, swf, thm, est, esten, ol, mb, o1, o2, uv, pnl, fwd, rev, rt, key, pwr;
  logic        gcmd, gfb, bcf, bkr, bad_gate, brake_stuck;
  logic [15:0] freq;
  logic [3:0]  s1, s2;
  logic        shut, fok, rok, rstb, uvs, pce, rlim, psi, irq;
  int          mismatches, comparisons;
  int unsigned seed = 4443;
  logic [7:0]  code_q[$];

  dftm_top #(.MS_CYCLES(4)) uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .phase_missing(ph), .sw_stage_fault(swf), .motor_thermistor_input(thm), .brake_confirm(bcf),
    .emergency_stop_input(est), .emergency_stop_enable_switch(esten), .overload_detect(ol),
    .modbus_timeout(mb), .opt1_error(o1), .opt2_error(o2), .undervoltage(uv), .panel_link_error(pnl),
    .run_fwd_cmd(fwd), .run_rev_cmd(rev), .trip_reset_terminal(rt), .panel_reset_key(key),
    .power_lost(pwr), .gate_feedback(gfb), .gate_cmd(gcmd), .out_freq_chz(freq), .opt1_subcode(s1),
    .opt2_subcode(s2), .output_shutoff(shut), .brake_release(bkr), .run_fwd_ok(fok), .run_rev_ok(rok),
    .err_code(err), .restart_standby(rstb), .uv_standby(uvs), .panel_comm_err(pce), .run_limited(rlim),
    .power_shutoff_ind(psi), .irq(irq));

  dftm_plant plant (.core_clk(core_clk), .gate_cmd(gcmd), .brake_release(bkr), .bad_gate(bad_gate),
    .brake_stuck(brake_stuck), .gate_feedback(gfb), .brake_confirm(bcf));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Model: expected code queued, then the design must latch it and block output
  task automatic wait_code(logic [7:0] exp);
    int n;
    code_q.push_back(exp);
    n = 0;
    while (err === 8'h00 && n < 6000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 6000)
    begin
      mismatches++;
      wrap_up();
    end
    step(2);
    chk(err, code_q.pop_front());
    chk(shut, 1);
  endtask

  task automatic clr(logic term);
    if (term)
      rt <= 1'b1;
    else
      key <= 1'b1;
    step(4);
    rt  <= 1'b0;
    key <= 1'b0;
    step(6);
  endtask

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, ph, swf, thm, est, esten, ol, mb, o1, o2} = '0;
    {uv, pnl, fwd, rev, rt, key, pwr, bad_gate, brake_stuck, s1, s2} = '0;
    gcmd = 1'b1;
    freq = 16'h0100;
    step(4);
    rst_n <= 1'b1;
    step(2);
    apb(0, dftm_pkg::OFS_CTRL, 0);
    chk(rd, dftm_pkg::CTRL_RST);
    apb(0, dftm_pkg::OFS_BRAKE, 0);
    chk(rd, dftm_pkg::BRAKE_RST);
    apb(0, 8'h40, 0);
    chk(serr, 1);
    chk(rd, 0);
    apb(1, dftm_pkg::OFS_IMASK, 32'h0000_000f);
    $display("registers done");
    thm <= 1'b1;
    wait_code(dftm_pkg::ERR_THERM);
    chk(irq, 1);
    apb(0, dftm_pkg::OFS_ISTAT, 0);
    chk(rd[0], 1);
    thm <= 1'b0;
    clr(0);
    chk(err, 0);
    chk(shut, 0);
    esten <= 1'b1;
    est   <= 1'b1;
    wait_code(dftm_pkg::ERR_ESTOP);
    est <= 1'b0;
    clr(0);
    chk(err, dftm_pkg::ERR_ESTOP);
    clr(1);
    chk(err, 0);
    $display("thermistor and stop done");
    apb(1, dftm_pkg::OFS_CTRL, 32'h0000_0041);
    swf <= 1'b1;
    wait_code(dftm_pkg::ERR_SW);
    step(8);
    chk(rstb, 0);
    swf <= 1'b0;
    clr(1);
    ph <= 1'b1;
    wait_code(dftm_pkg::ERR_PHASE);
    ph <= 1'b0;
    step(4);
    chk(rstb, 1);
    for (int n = 0; n < 6000 && rstb === 1'b1; n++)
      step(1);
    chk(rstb, 0);
    if (rstb !== 1'b0)
      wrap_up();
    $display("phase and retry done");
    apb(1, dftm_pkg::OFS_CTRL, 0);
    clr(0);
    freq <= 16'(xs() % 21);
    ol   <= 1'b1;
    wait_code(dftm_pkg::ERR_LS);
    ol   <= 1'b0;
    freq <= 16'h0100;
    // Let the accumulator fall below its limit, else the reset re-trips
    step(8);
    clr(0);
    apb(1, dftm_pkg::OFS_CTRL, 32'h0000_0004);
    mb <= 1'b1;
    step(8);
    chk(err, 0);
    apb(0, dftm_pkg::OFS_ISTAT, 0);
    chk(rd[1], 1);
    mb <= 1'b0;
    apb(1, dftm_pkg::OFS_CTRL, 0);
    mb <= 1'b1;
    wait_code(dftm_pkg::ERR_MODBUS);
    mb <= 1'b0;
    clr(0);
    for (int p = 0; p < 2; p++)
    begin
      s1 <= 4'(xs());
      s2 <= 4'(xs());
      step(1);
      if (p == 0)
        o1 <= 1'b1;
      else
        o2 <= 1'b1;
      wait_code(p == 0 ? (dftm_pkg::ERR_OPT1 | 8'(s1)) : (dftm_pkg::ERR_OPT2 | 8'(s2)));
      o1 <= 1'b0;
      o2 <= 1'b0;
      clr(0);
    end
    $display("overload comm option done");
    apb(1, dftm_pkg::OFS_BRAKE, 32'h0000_0002);
    apb(1, dftm_pkg::OFS_CTRL, 32'h0000_0002);
    brake_stuck <= 1'b1;
    fwd <= 1'b1;
    step(6);
    chk(fok, 1);
    chk(bkr, 1);
    wait_code(dftm_pkg::ERR_BRAKE);
    fwd <= 1'b0;
    brake_stuck <= 1'b0;
    clr(0);
    apb(1, dftm_pkg::OFS_CTRL, 32'h0000_0010);
    rev <= 1'b1;
    step(6);
    chk(rlim, 1);
    chk(rok, 0);
    rev <= 1'b0;
    apb(1, dftm_pkg::OFS_CTRL, 32'h0000_0020);
    fwd <= 1'b1;
    step(6);
    chk(rlim, 1);
    chk(fok, 0);
    fwd <= 1'b0;
    uv  <= 1'b1;
    pnl <= 1'b1;
    pwr <= 1'b1;
    step(6);
    chk(uvs, 1);
    chk(pce, 1);
    chk(psi, 1);
    chk(shut, 1);
    apb(0, dftm_pkg::OFS_STAT, 0);
    chk(rd[13:10], 4'hb);
    {uv, pnl, pwr} <= 3'h0;
    step(6);
    $display("brake direction indications done");
    bad_gate <= 1'b1;
    wait_code(dftm_pkg::ERR_MAIN);
    bad_gate <= 1'b0;
    clr(1);
    clr(0);
    chk(err, dftm_pkg::ERR_MAIN);
    rst_n <= 1'b0;
    step(4);
    rst_n <= 1'b1;
    step(2);
    chk(err, 0);
    $display("main circuit done");
    wrap_up();
  end
endmodule
